// ==== verilog/fpec_ctrl.sv ====
// flash program/erase control registers with axi4-lite slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fpec_cfg.svh"
// ------------------------------------------------------------
// Overview of operation
// - bit 7 of control one reads the hardware write-enable pin level
// - bit 6 of control one is software write enable, reset 0
// - software enable 0 refuses setting other control bits and block bits
// - erase-setup bit 5 enters or cancels erase setup state
// - program-setup bit 4 enters or cancels program setup state
// - erase-verify bit 3 enters or leaves erase-verify mode
// - program-verify bit 2 enters or leaves program-verify mode
// - erase-go bit 1 erases only with software enable and erase-setup
// - program-go bit 0 programs only with software enable and setup
// - error flag bit 7 set on fault forces error protection
// - status two bits 6 to 0 read as zero
// - erase block select held at zero while software enable is 0
// - writing more than one block bit clears the whole register
// - bits 0 to 3 select four 1-kbyte blocks from address zero
// - bit 4 selects the 28-kbyte block
// - bit 5 selects the 16-kbyte block
// - bits 6 and 7 select the two 8-kbyte blocks
// - hardware write-enable pin protects program and erase on its own
// - mode pins and write enable at reset end pick user or boot
// ------------------------------------------------------------
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              hw_write_enable,
  input  wire logic              mode_select_pin_2,
  input  wire logic              mode_select_pin_1,
  input  wire logic              mode_select_pin_0,
  input  wire logic              array_fault,
  output fpec_state_e            array_state,
  output logic [7:0]             erase_block_sel,
  output fpec_addr_t             erase_first_addr,
  output fpec_addr_t             erase_last_addr,
  output logic                   error_protect,
  output logic                   boot_mode,
  output logic                   user_mode
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic many_bits(input logic [7:0] v);
    many_bits = (v & (v - 8'h01)) != 8'h00;
  endfunction

  function automatic fpec_addr_t blk_start(input logic [3:0] i);
    case (i)
      4'h0:    blk_start = `FPEC_EB0_START;
      4'h1:    blk_start = `FPEC_EB1_START;
      4'h2:    blk_start = `FPEC_EB2_START;
      4'h3:    blk_start = `FPEC_EB3_START;
      4'h4:    blk_start = `FPEC_EB4_START;
      4'h5:    blk_start = `FPEC_EB5_START;
      4'h6:    blk_start = `FPEC_EB6_START;
      4'h7:    blk_start = `FPEC_EB7_START;
      default: blk_start = `FPEC_EB_TOP;
    endcase
  endfunction

  function automatic logic [3:0] blk_index(input logic [7:0] v);
    blk_index = 4'h8;
    for (int k = 0; k < 8; k++) begin
      if (v[k]) begin
        blk_index = 4'(k);
      end
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [6:0]        ctl_r;
  logic [7:0]        eb_r;
  logic              err_r;
  logic              hwwe_r;
  logic              rst_seen_r;
  logic              boot_r;
  logic              user_r;
  fpec_state_e       state_r;
  fpec_addr_t        first_r;
  fpec_addr_t        last_r;
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // ------------------------------------------------------------
  // write channel decode
  // ------------------------------------------------------------
  wire aw_take   = s_axi_awvalid & awready_r;
  wire w_take    = s_axi_wvalid & wready_r;
  wire do_write  = aw_hold_r & w_hold_r;
  wire wr_ctl    = do_write & wlane_r & (awaddr_r == ADDR_W'(`FPEC_OFS_CTL1));
  wire wr_eb     = do_write & wlane_r & (awaddr_r == ADDR_W'(`FPEC_OFS_EBSEL));
  wire wr_mapped = (awaddr_r == ADDR_W'(`FPEC_OFS_CTL1))
                 | (awaddr_r == ADDR_W'(`FPEC_OFS_STAT2))
                 | (awaddr_r == ADDR_W'(`FPEC_OFS_EBSEL))
                 | (awaddr_r == ADDR_W'(`FPEC_OFS_INFO));
  wire aw_hold_nxt = (aw_hold_r | aw_take) & ~do_write;
  wire w_hold_nxt  = (w_hold_r | w_take) & ~do_write;
  wire bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);

  // ------------------------------------------------------------
  // control register next value
  // ------------------------------------------------------------
  wire       swwe    = ctl_r[`FPEC_B_SWWE];
  // with software enable low, only clears get through
  wire [5:0] ctl_wr  = wbyte_r[5:0] & (swwe ? 6'h3f : ctl_r[5:0]);
  // software enable itself is always writable
  wire [6:0] ctl_nxt = wr_ctl ? {wbyte_r[`FPEC_B_SWWE], ctl_wr}
                              : ctl_r;
  wire       swwe_nxt = ctl_nxt[`FPEC_B_SWWE];
  wire [7:0] eb_wr    = many_bits(wbyte_r) ? 8'h00 : wbyte_r;
  wire [7:0] eb_nxt   = ~swwe_nxt ? `FPEC_RST_EB
                      : (wr_eb & swwe) ? eb_wr : eb_r;
  wire       err_nxt  = err_r | array_fault;

  // ------------------------------------------------------------
  // array state from control bits
  // ------------------------------------------------------------
  wire         wr_ok   = swwe_nxt & hwwe_r & ~err_nxt;
  fpec_state_e state_nxt;
  always_comb begin
    if (err_nxt) begin
      state_nxt = FPEC_ERRPROT;
    end else if (wr_ok & ctl_nxt[`FPEC_B_ESU] & ctl_nxt[`FPEC_B_EGO]) begin
      state_nxt = FPEC_ERASE;
    end else if (wr_ok & ctl_nxt[`FPEC_B_PSU] & ctl_nxt[`FPEC_B_PGO]) begin
      state_nxt = FPEC_PROG;
    end else if (ctl_nxt[`FPEC_B_EV]) begin
      state_nxt = FPEC_EVERIFY;
    end else if (ctl_nxt[`FPEC_B_PV]) begin
      state_nxt = FPEC_PVERIFY;
    end else if (ctl_nxt[`FPEC_B_ESU]) begin
      state_nxt = FPEC_ESETUP;
    end else if (ctl_nxt[`FPEC_B_PSU]) begin
      state_nxt = FPEC_PSETUP;
    end else begin
      state_nxt = FPEC_IDLE;
    end
  end

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  wire ar_take    = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  wire [7:0] ctl_rd  = {hwwe_r, ctl_r};
  wire [7:0] stat_rd = {err_r, 7'h00};
  wire [7:0] info_rd = {6'h00, boot_r, user_r};
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`FPEC_OFS_CTL1):  rd_byte = ctl_rd;
      ADDR_W'(`FPEC_OFS_STAT2): rd_byte = stat_rd;
      ADDR_W'(`FPEC_OFS_EBSEL): rd_byte = eb_r;
      ADDR_W'(`FPEC_OFS_INFO):  rd_byte = info_rd;
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // erase window of selected block
  // ------------------------------------------------------------
  wire [3:0]  eb_idx    = blk_index(eb_nxt);
  wire        eb_none   = eb_idx == 4'h8;
  fpec_addr_t first_nxt;
  fpec_addr_t last_nxt;
  assign first_nxt = eb_none ? 24'h000000 : blk_start(eb_idx);
  assign last_nxt  = eb_none ? 24'h000000
                   : blk_start(eb_idx + 4'h1) - 24'h000001;

  // ------------------------------------------------------------
  // axi handshake flops
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `FPEC_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `FPEC_RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (do_write) begin
        bresp_r <= wr_mapped ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
      wbyte_r  <= 8'h00;
      wlane_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
    end
  end

  // ------------------------------------------------------------
  // control, status and mode flops
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r   <= `FPEC_RST_CTL;
      eb_r    <= `FPEC_RST_EB;
      err_r   <= 1'b0;
      hwwe_r  <= 1'b0;
      state_r <= FPEC_IDLE;
      first_r <= 24'h000000;
      last_r  <= 24'h000000;
    end else begin
      ctl_r   <= ctl_nxt;
      eb_r    <= eb_nxt;
      err_r   <= err_nxt;
      hwwe_r  <= hw_write_enable;
      state_r <= state_nxt;
      first_r <= first_nxt;
      last_r  <= last_nxt;
    end
  end

  // mode pins caught at the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_seen_r <= 1'b0;
      boot_r     <= 1'b0;
      user_r     <= 1'b0;
    end else if (!rst_seen_r) begin
      rst_seen_r <= 1'b1;
      user_r <= mode_select_pin_2 & mode_select_pin_1
              & mode_select_pin_0 & hw_write_enable;
      boot_r <= ~mode_select_pin_2 & mode_select_pin_1
              & mode_select_pin_0 & hw_write_enable;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready    = awready_r;
  assign s_axi_wready     = wready_r;
  assign s_axi_bvalid     = bvalid_r;
  assign s_axi_bresp      = bresp_r;
  assign s_axi_arready    = arready_r;
  assign s_axi_rvalid     = rvalid_r;
  assign s_axi_rdata      = rdata_r;
  assign s_axi_rresp      = rresp_r;
  assign array_state      = state_r;
  assign erase_block_sel  = eb_r;
  assign erase_first_addr = first_r;
  assign erase_last_addr  = last_r;
  assign error_protect    = err_r;
  assign boot_mode        = boot_r;
  assign user_mode        = user_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ebsel_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_r[`FPEC_B_SWWE] |-> eb_r == 8'h00)
    else $error("block select not zero with software enable low");

  a_ebsel_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    !many_bits(eb_r))
    else $error("block select holds several bits");

  a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    err_r |=> err_r)
    else $error("error flag dropped without reset");

  a_err_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    array_fault |=> err_r && state_r == FPEC_ERRPROT)
    else $error("fault did not force error protection");

  a_erase_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == FPEC_ERASE |-> ctl_r[`FPEC_B_SWWE] && ctl_r[`FPEC_B_ESU]
      && ctl_r[`FPEC_B_EGO] && $past(hwwe_r) && !err_r)
    else $error("erase mode without its enables");

  a_prog_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == FPEC_PROG |-> ctl_r[`FPEC_B_SWWE] && ctl_r[`FPEC_B_PSU]
      && ctl_r[`FPEC_B_PGO] && $past(hwwe_r) && !err_r)
    else $error("program mode without its enables");

  // pin passes one flop before it gates the state
  a_hw_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    !hw_write_enable ##1 !hw_write_enable |=> state_r != FPEC_ERASE && state_r != FPEC_PROG)
    else $error("program or erase with hardware enable low");

  a_no_set_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_r[`FPEC_B_SWWE] |=> (ctl_r[5:0] & ~$past(ctl_r[5:0])) == 6'h00)
    else $error("control bit set with software enable low");

  a_stat_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_araddr) == ADDR_W'(`FPEC_OFS_STAT2)
      && $past(ar_take) |-> s_axi_rdata[6:0] == 7'h00)
    else $error("reserved status bits not zero");

  a_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");

  a_blk_first: assert property (@(posedge aclk) disable iff (!aresetn)
    eb_r == 8'h01 |-> erase_first_addr == 24'h000000 && erase_last_addr == 24'h0003ff)
    else $error("block zero window wrong");

endmodule

// ==== verilog/fpec_cfg.svh ====
// offsets, field positions, reset values and block addresses of the flash control block
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FPEC_OFS_CTL1   8'h00
`define FPEC_OFS_STAT2  8'h04
`define FPEC_OFS_EBSEL  8'h08
`define FPEC_OFS_INFO   8'h0c

// ------------------------------------------------------------
// control register one fields
// ------------------------------------------------------------
`define FPEC_B_HWWE   7
`define FPEC_B_SWWE   6
`define FPEC_B_ESU    5
`define FPEC_B_PSU    4
`define FPEC_B_EV     3
`define FPEC_B_PV     2
`define FPEC_B_EGO    1
`define FPEC_B_PGO    0

// ------------------------------------------------------------
// status register two and info register fields
// ------------------------------------------------------------
`define FPEC_B_ERR    7
`define FPEC_B_BOOT   1
`define FPEC_B_USER   0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FPEC_RST_CTL  7'h00
`define FPEC_RST_EB   8'h00

// ------------------------------------------------------------
// erase block start addresses, the last entry closes block 7
// ------------------------------------------------------------
`define FPEC_EB0_START 24'h000000
`define FPEC_EB1_START 24'h000400
`define FPEC_EB2_START 24'h000800
`define FPEC_EB3_START 24'h000c00
`define FPEC_EB4_START 24'h001000
`define FPEC_EB5_START 24'h008000
`define FPEC_EB6_START 24'h00c000
`define FPEC_EB7_START 24'h00e000
`define FPEC_EB_TOP    24'h010000

// ------------------------------------------------------------
// axi responses
// ------------------------------------------------------------
`define FPEC_RESP_OKAY   2'h0
`define FPEC_RESP_SLVERR 2'h2

`endif

// ==== verilog/fpec_pkg.sv ====
// types shared by the flash program/erase control block
package fpec_pkg;

  // ------------------------------------------------------------
  // array operating state, one-hot
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    FPEC_IDLE    = 8'h01,
    FPEC_ESETUP  = 8'h02,
    FPEC_PSETUP  = 8'h04,
    FPEC_EVERIFY = 8'h08,
    FPEC_PVERIFY = 8'h10,
    FPEC_ERASE   = 8'h20,
    FPEC_PROG    = 8'h40,
    FPEC_ERRPROT = 8'h80
  } fpec_state_e;

  typedef logic [23:0] fpec_addr_t;

endpackage

// ==== testbench/fpec_pins_model.sv ====
// pin-level model of the flash array and the board straps around the control block
`timescale 1ns/1ps
module fpec_pins_model (
  input  wire logic       aclk,
  input  wire logic       hwe_cmd,
  input  wire logic [2:0] mode_cmd,
  input  wire logic       fault_cmd,
  output logic            hw_write_enable,
  output logic            mode_select_pin_2,
  output logic            mode_select_pin_1,
  output logic            mode_select_pin_0,
  output logic            array_fault
);
  // straps and enable pin held steady across reset end
  always_ff @(posedge aclk) begin
    hw_write_enable <= hwe_cmd;
    {mode_select_pin_2, mode_select_pin_1, mode_select_pin_0} <= mode_cmd;
    array_fault <= fault_cmd;  // one pulse per commanded array error
  end
endmodule

// ==== testbench/flash_program_erase_control_bench.sv ====
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module flash_program_erase_control_bench import fpec_pkg::*;;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        hwe_cmd = 1, fault_cmd = 0;
  logic [2:0]  mode_cmd = 3'h7;
  logic        hw_we, md2, md1, md0, fault, eprot, bootm, userm;
  fpec_state_e st;
  logic [7:0]  ebs, v;
  fpec_addr_t  ea0, ea1;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [34:0] exp_q[$];
  logic [23:0] starts [9] = '{24'h000000, 24'h000400, 24'h000800, 24'h000c00, 24'h001000,
                              24'h008000, 24'h00c000, 24'h00e000, 24'h010000};

  always #2.5 aclk = ~aclk;

  fpec_pins_model pins (.aclk(aclk), .hwe_cmd(hwe_cmd), .mode_cmd(mode_cmd),
    .fault_cmd(fault_cmd), .hw_write_enable(hw_we), .mode_select_pin_2(md2),
    .mode_select_pin_1(md1), .mode_select_pin_0(md0), .array_fault(fault));

  fpec_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_write_enable(hw_we), .mode_select_pin_2(md2),
    .mode_select_pin_1(md1), .mode_select_pin_0(md0), .array_fault(fault),
    .array_state(st), .erase_block_sel(ebs), .erase_first_addr(ea0),
    .erase_last_addr(ea1), .error_protect(eprot), .boot_mode(bootm), .user_mode(userm));

  // ------------------------------------------------------------
  // comparison, verdict and bus tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] cv(input logic [6:0] x);
    return {24'h0, hwe_cmd, x};
  endfunction

  // readiness is looked at mid-cycle, where it equals what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_t, w_t, b_t;
    exp_q.push_back({1'b1, r, 32'h0});
    b_t = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      @(posedge aclk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic t;
    exp_q.push_back({1'b0, r, d});
    t = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 0;
    t = 0;
    while (!t) begin
      @(negedge aclk);
      t = rvalid;
      @(posedge aclk);
    end
    rready <= 0;
    @(posedge aclk);
  endtask

  task automatic wst(input logic [7:0] d, input fpec_state_e s);
    wr(`FPEC_OFS_CTL1, d, `FPEC_RESP_OKAY);
    @(negedge aclk);
    check("array_state", {24'h0, st}, {24'h0, s});
    @(posedge aclk);
  endtask

  task automatic do_reset(input logic [2:0] m);
    mode_cmd <= m;
    aresetn <= 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    @(negedge aclk);
    check("user_mode", {31'h0, userm}, {31'h0, m == 3'h7 && hwe_cmd});
    check("boot_mode", {31'h0, bootm}, {31'h0, m == 3'h3 && hwe_cmd});
    check("error_protect", {31'h0, eprot}, 32'h0);
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // response monitor, oldest note first
  // ------------------------------------------------------------
  always @(negedge aclk) begin
    logic [34:0] e;
    if (bvalid && bready) begin
      e = exp_q.pop_front();
      check("bresp", {30'h0, bresp}, {30'h0, e[33:32]});
    end
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
      check("rdata", rdata, e[31:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'hcbc6));
    do_reset(3'h7);
    rd(`FPEC_OFS_CTL1, cv(7'h00), `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_STAT2, 32'h0, `FPEC_RESP_OKAY);
    wr(`FPEC_OFS_CTL1, 8'h3f, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_CTL1, cv(7'h00), `FPEC_RESP_OKAY);
    wr(`FPEC_OFS_EBSEL, 8'h01, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_EBSEL, 32'h0, `FPEC_RESP_OKAY);
    wr(`FPEC_OFS_CTL1, 8'h7f, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_CTL1, cv(7'h40), `FPEC_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(`FPEC_OFS_EBSEL, 8'h01 << i, `FPEC_RESP_OKAY);
      rd(`FPEC_OFS_EBSEL, 32'h1 << i, `FPEC_RESP_OKAY);
      @(negedge aclk);
      check("erase_block_sel", {24'h0, ebs}, 32'h1 << i);
      check("erase_first", {8'h0, ea0}, {8'h0, starts[i]});
      check("erase_last", {8'h0, ea1}, {8'h0, starts[i+1] - 24'h1});
      @(posedge aclk);
    end
    wr(`FPEC_OFS_EBSEL, 8'h03, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_EBSEL, 32'h0, `FPEC_RESP_OKAY);
    repeat (6) begin
      v = 8'($urandom);
      wr(`FPEC_OFS_EBSEL, v, `FPEC_RESP_OKAY);
      rd(`FPEC_OFS_EBSEL, $onehot(v) ? {24'h0, v} : 32'h0, `FPEC_RESP_OKAY);
    end
    wr(`FPEC_OFS_EBSEL, 8'h10, `FPEC_RESP_OKAY);
    wst(8'h00, FPEC_IDLE);
    rd(`FPEC_OFS_EBSEL, 32'h0, `FPEC_RESP_OKAY);
    wst(8'h40, FPEC_IDLE);
    wst(8'h60, FPEC_ESETUP);
    wst(8'h62, FPEC_ERASE);
    wst(8'h60, FPEC_ESETUP);
    wst(8'h42, FPEC_IDLE);
    wst(8'h50, FPEC_PSETUP);
    wst(8'h51, FPEC_PROG);
    wst(8'h41, FPEC_IDLE);
    wst(8'h48, FPEC_EVERIFY);
    wst(8'h40, FPEC_IDLE);
    wst(8'h44, FPEC_PVERIFY);
    wst(8'h40, FPEC_IDLE);
    hwe_cmd <= 0;
    repeat (3) @(posedge aclk);
    wst(8'h62, FPEC_ESETUP);
    rd(`FPEC_OFS_CTL1, cv(7'h62), `FPEC_RESP_OKAY);
    hwe_cmd <= 1;
    repeat (3) @(posedge aclk);
    wst(8'h62, FPEC_ERASE);
    wr(8'h10, 8'h00, `FPEC_RESP_SLVERR);
    rd(8'h10, 32'h0, `FPEC_RESP_SLVERR);
    wstrb <= 4'h0;
    wr(`FPEC_OFS_CTL1, 8'h00, `FPEC_RESP_OKAY);
    wstrb <= 4'h1;
    rd(`FPEC_OFS_CTL1, cv(7'h62), `FPEC_RESP_OKAY);
    wr(`FPEC_OFS_INFO, 8'hff, `FPEC_RESP_OKAY);  // status two left unwritten
    rd(`FPEC_OFS_INFO, 32'h1, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_STAT2, 32'h0, `FPEC_RESP_OKAY);
    fault_cmd <= 1;
    @(posedge aclk);
    fault_cmd <= 0;
    repeat (3) @(posedge aclk);
    rd(`FPEC_OFS_STAT2, 32'h80, `FPEC_RESP_OKAY);
    wst(8'h51, FPEC_ERRPROT);
    @(negedge aclk);
    check("error_protect", {31'h0, eprot}, 32'h1);
    @(posedge aclk);
    do_reset(3'h3);
    rd(`FPEC_OFS_STAT2, 32'h0, `FPEC_RESP_OKAY);
    rd(`FPEC_OFS_CTL1, cv(7'h00), `FPEC_RESP_OKAY);
    summarize();
  end
endmodule
